// >>> hdl/sbw_pkg.sv
// Purpose: Shared constants for the break, wake and sync-master serial block
// Assumes: 32-bit classic Wishbone register port, one register per word
// Notes: Bit period is held in clock cycles, set through the rate register
`default_nettype none
package sbw_pkg;
    // Register byte offsets
    localparam logic [7:0] SBW_CTRL_OFS = 8'h00;
    localparam logic [7:0] SBW_STAT_OFS = 8'h04;
    localparam logic [7:0] SBW_TXD_OFS = 8'h08;
    localparam logic [7:0] SBW_RXD_OFS = 8'h0C;
    localparam logic [7:0] SBW_RATE_OFS = 8'h10;
    // Control register fields
    localparam int SBW_C_TRANSMIT_ENABLE = 0;
    localparam int SBW_C_BREAK_SEND_REQUEST = 1;
    localparam int SBW_C_SYNC = 2;
    localparam int SBW_C_CLOCK_SOURCE_MASTER = 3;
    localparam int SBW_C_PEN = 4;
    localparam int SBW_C_SINGLE_RECEIVE_ENABLE = 5;
    localparam int SBW_C_CONTINUOUS_RECEIVE_ENABLE = 6;
    localparam int SBW_C_POL = 7;
    localparam int SBW_C_WUE = 8;
    localparam int SBW_C_W = 9;
    // Status register fields
    localparam int SBW_S_SHIFT_REG_EMPTY = 0;
    localparam int SBW_S_TRANSMIT_BUFFER_EMPTY_FLAG = 1;
    localparam int SBW_S_RECEIVE_FLAG = 2;
    localparam int SBW_S_FRAMING_ERROR = 3;
    localparam int SBW_S_RIDL = 4;
    // Reset values
    localparam logic [8:0] SBW_CTRL_RST = 9'h000;
    localparam logic [15:0] SBW_RATE_RST = 16'h0364;
    // Frame shapes, shifted out least significant bit first
    localparam logic [3:0] SBW_ASYNC_BITS = 4'hA;
    localparam logic [3:0] SBW_BRK_BITS = 4'hE;
    localparam logic [3:0] SBW_SYNC_BITS = 4'h8;
    localparam logic [13:0] SBW_BRK_FRAME = 14'h2000;
    localparam logic [3:0] SBW_FILL_ASYNC = 4'hF;
    localparam logic [5:0] SBW_FILL_SYNC = 6'h3F;
    localparam logic [3:0] SBW_RX_BITS = 4'h8;
endpackage
`default_nettype wire

// >>> hdl/sbw_rx.sv
// Purpose: Asynchronous character receiver, one start, eight data, one stop
// Assumes: Data line already brought onto clk_i by two flip-flops
// Notes: After a framing error it waits for the line to go high again
`default_nettype none
module sbw_rx
    import sbw_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic en_i,
    input wire logic rxd_i,
    input wire logic [15:0] bit_cycles_i,
    // Result
    output logic done_o,
    output logic [7:0] data_o,
    output logic framing_error_o,
    output logic idle_o
);
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HOLD
    } sbw_rx_st_t;

    sbw_rx_st_t st_q;
    logic [15:0] tmr_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic tick;

    assign tick = (tmr_q == 16'h0000);
    assign idle_o = (st_q == RX_IDLE);

    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            st_q <= RX_IDLE;
            tmr_q <= 16'h0000;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            done_o <= 1'b0;
            data_o <= 8'h00;
            framing_error_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            tmr_q <= tick ? bit_cycles_i - 16'h0001 : tmr_q - 16'h0001;
            case (st_q)
                RX_IDLE: begin
                    // Sample in the middle of each bit
                    tmr_q <= {1'b0, bit_cycles_i[15:1]};
                    if (!rxd_i) begin
                        st_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        st_q <= rxd_i ? RX_IDLE : RX_DATA;
                        cnt_q <= SBW_RX_BITS;
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        sh_q <= {rxd_i, sh_q[7:1]};
                        cnt_q <= cnt_q - 4'h1;
                        if (cnt_q == 4'h1) begin
                            st_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        done_o <= 1'b1;
                        data_o <= sh_q;
                        framing_error_o <= !rxd_i;
                        st_q <= rxd_i ? RX_IDLE : RX_HOLD;
                    end
                end
                RX_HOLD: begin
                    if (rxd_i) begin
                        st_q <= RX_IDLE;
                    end
                end
                default: st_q <= RX_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> hdl/sbw_top.sv
// Purpose: Serial port slice: wake on break, break send, sync master send
// Assumes: Classic Wishbone slave, 100 MHz clock, line inputs asynchronous
// Notes: Sync receive, slave clocking and rate detection are not built
`default_nettype none
module sbw_top
    import sbw_pkg::*;
#(
    parameter logic [15:0] RATE_RST = SBW_RATE_RST
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Data line, two-way
    input wire logic data_line_i,
    output logic data_line_o,
    output logic data_line_oe_o,
    // Clock line: async transmit out or sync master clock
    output logic clock_line_o,
    output logic clock_line_oe_o
);
    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} sbw_tx_st_t;

    function automatic logic [31:0] sbw_merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Bus decode
    logic req, wr_hit, rd_hit;
    logic [SBW_C_W-1:0] ctrl_q;
    logic [15:0] rate_q;
    logic [31:0] ctrl_m, rate_m;
    assign req = cyc_i && stb_i;
    assign wr_hit = req && ack_o && we_i;
    assign rd_hit = req && ack_o && !we_i;
    assign ctrl_m = sbw_merge({23'h0, ctrl_q}, dat_i, sel_i);
    assign rate_m = sbw_merge({16'h0, rate_q}, dat_i, sel_i);

    // Mode decode
    logic transmit_enable, break_send_request, sync, pen, pol, wake_on_break_enable;
    logic sync_mst, sync_tx, async_on;
    assign transmit_enable = ctrl_q[SBW_C_TRANSMIT_ENABLE];
    assign break_send_request = ctrl_q[SBW_C_BREAK_SEND_REQUEST];
    assign sync = ctrl_q[SBW_C_SYNC];
    assign pen = ctrl_q[SBW_C_PEN];
    assign pol = ctrl_q[SBW_C_POL];
    assign wake_on_break_enable = ctrl_q[SBW_C_WUE];
    assign sync_mst = sync && ctrl_q[SBW_C_CLOCK_SOURCE_MASTER] && pen;
    assign sync_tx = sync_mst && !ctrl_q[SBW_C_SINGLE_RECEIVE_ENABLE]
        && !ctrl_q[SBW_C_CONTINUOUS_RECEIVE_ENABLE];
    assign async_on = pen && !sync;

    // Line input synchroniser and edges
    logic rx_s1_q, rx_s2_q, rx_s3_q, rx_fall, rx_rise;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
        end else begin
            rx_s1_q <= data_line_i;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
        end
    end
    assign rx_fall = rx_s3_q && !rx_s2_q;
    assign rx_rise = !rx_s3_q && rx_s2_q;

    // Wake logic
    logic wake_on, wake_ev, wue_clr;
    assign wake_on = wake_on_break_enable && async_on;
    assign wake_ev = wake_on && rx_fall;
    assign wue_clr = wake_on && rx_rise;

    // Receiver, held idle while waiting for a wake event
    logic rx_en, rx_done, rx_framing_error, rx_idle;
    logic [7:0] rx_data;
    assign rx_en = async_on && ctrl_q[SBW_C_CONTINUOUS_RECEIVE_ENABLE] && !wake_on_break_enable;
    sbw_rx u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(rx_en),
        .rxd_i(rx_s2_q),
        .bit_cycles_i(rate_q),
        .done_o(rx_done),
        .data_o(rx_data),
        .framing_error_o(rx_framing_error),
        .idle_o(rx_idle)
    );

    logic receive_flag_q, framing_error_q;
    logic [7:0] rxbuf_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            receive_flag_q <= 1'b0;
            framing_error_q <= 1'b0;
            rxbuf_q <= 8'h00;
        end else begin
            // Setting beats the read clear in the same cycle
            if (rx_done || wake_ev) begin
                receive_flag_q <= 1'b1;
            end else if (rd_hit && adr_i == SBW_RXD_OFS) begin
                receive_flag_q <= 1'b0;
            end
            if (rx_done) begin
                rxbuf_q <= rx_data;
                framing_error_q <= rx_framing_error;
            end
        end
    end

    // Transmit engine state
    sbw_tx_st_t st_q;
    logic [13:0] tsr_q;
    logic [3:0] bits_q;
    logic [15:0] tmr_q;
    logic brk_q, ph_q, sclk_q;
    logic [7:0] txbuf_q;
    logic txfull_q, load, tick, last, brk_done;
    assign tick = (tmr_q == 16'h0000);
    assign last = (bits_q == 4'h1);
    // A sync load waits for the clock to sit at its idle level, so a
    // polarity change never swallows the first leading edge
    assign load = (st_q == TX_IDLE) && txfull_q && transmit_enable
        && (async_on || (sync_tx && sclk_q == pol));
    assign brk_done = (st_q == TX_ASYNC) && tick && last && brk_q;

    // Control and rate registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= SBW_CTRL_RST;
            rate_q <= RATE_RST;
        end else begin
            if (wue_clr) begin
                ctrl_q[SBW_C_WUE] <= 1'b0;
            end
            if (brk_done) begin
                ctrl_q[SBW_C_BREAK_SEND_REQUEST] <= 1'b0;
            end
            if (wr_hit && adr_i == SBW_CTRL_OFS) begin
                ctrl_q <= ctrl_m[SBW_C_W-1:0];
            end
            if (wr_hit && adr_i == SBW_RATE_OFS) begin
                rate_q <= rate_m[15:0];
            end
        end
    end

    // Transmit buffer: one word ahead of the shift register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txbuf_q <= 8'h00;
            txfull_q <= 1'b0;
        end else if (wr_hit && adr_i == SBW_TXD_OFS && sel_i[0] && transmit_enable) begin
            // Write while full overwrites; software waits on the flag
            txbuf_q <= dat_i[7:0];
            txfull_q <= 1'b1;
        end else if (load) begin
            txfull_q <= 1'b0;
        end
    end

    // Shift register and bit timing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= TX_IDLE;
            tsr_q <= {14{1'b1}};
            bits_q <= 4'h0;
            tmr_q <= 16'h0000;
            brk_q <= 1'b0;
            ph_q <= 1'b0;
        end else begin
            tmr_q <= tick ? rate_q - 16'h0001 : tmr_q - 16'h0001;
            case (st_q)
                TX_IDLE: begin
                    tmr_q <= rate_q - 16'h0001;
                    ph_q <= 1'b0;
                    if (load && sync_tx) begin
                        st_q <= TX_SYNC;
                        tsr_q <= {SBW_FILL_SYNC, txbuf_q};
                        bits_q <= SBW_SYNC_BITS;
                        brk_q <= 1'b0;
                    end else if (load && break_send_request) begin
                        st_q <= TX_ASYNC;
                        tsr_q <= SBW_BRK_FRAME;
                        bits_q <= SBW_BRK_BITS;
                        brk_q <= 1'b1;
                    end else if (load) begin
                        st_q <= TX_ASYNC;
                        tsr_q <= {SBW_FILL_ASYNC, 1'b1, txbuf_q, 1'b0};
                        bits_q <= SBW_ASYNC_BITS;
                        brk_q <= 1'b0;
                    end
                end
                TX_ASYNC: begin
                    if (tick) begin
                        tsr_q <= {1'b1, tsr_q[13:1]};
                        bits_q <= bits_q - 4'h1;
                        if (last) begin
                            st_q <= TX_IDLE;
                        end
                    end
                end
                TX_SYNC: begin
                    // Each bit is a leading half then a trailing half
                    if (tick) begin
                        ph_q <= !ph_q;
                        if (ph_q) begin
                            tsr_q <= {1'b1, tsr_q[13:1]};
                            bits_q <= bits_q - 4'h1;
                            if (last) begin
                                st_q <= TX_IDLE;
                            end
                        end
                    end
                end
                default: st_q <= TX_IDLE;
            endcase
        end
    end

    // Master clock: leading level for the first half of each bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
        end else if (load && sync_tx) begin
            sclk_q <= !pol;
        end else if (st_q == TX_SYNC && tick) begin
            sclk_q <= ph_q && !last ? !pol : pol;
        end else if (st_q != TX_SYNC) begin
            sclk_q <= pol;
        end
    end

    // Pins
    assign clock_line_o = sync_mst ? sclk_q
        : (st_q == TX_ASYNC ? tsr_q[0] : 1'b1);
    assign clock_line_oe_o = sync_mst || async_on;
    assign data_line_o = tsr_q[0];
    assign data_line_oe_o = sync_tx;

    // Register read and acknowledge, one wait state
    logic shift_reg_empty, transmit_buffer_empty_flag;
    assign shift_reg_empty = (st_q == TX_IDLE);
    assign transmit_buffer_empty_flag = !txfull_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req && !ack_o;
            dat_o <= 32'h0000_0000;
            if (req && !ack_o && !we_i) begin
                case (adr_i)
                    SBW_CTRL_OFS: dat_o <= {23'h0, ctrl_q};
                    SBW_STAT_OFS: begin
                        dat_o[SBW_S_SHIFT_REG_EMPTY] <= shift_reg_empty;
                        dat_o[SBW_S_TRANSMIT_BUFFER_EMPTY_FLAG] <= transmit_buffer_empty_flag;
                        dat_o[SBW_S_RECEIVE_FLAG] <= receive_flag_q;
                        dat_o[SBW_S_FRAMING_ERROR] <= framing_error_q;
                        dat_o[SBW_S_RIDL] <= rx_idle && !wake_on_break_enable;
                    end
                    SBW_RXD_OFS: dat_o <= {24'h0, rxbuf_q};
                    SBW_RATE_OFS: dat_o <= {16'h0, rate_q};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence brk_load_s;
        load && break_send_request && !sync_tx;
    endsequence
    sequence sync_load_s;
        load && sync_tx;
    endsequence

    brk_len_a: assert property (brk_load_s |=> bits_q == SBW_BRK_BITS
        && st_q == TX_ASYNC) else $error("break length wrong");
    brk_zero_a: assert property (st_q == TX_ASYNC && brk_q
        && bits_q > 4'h1 |-> clock_line_o == 1'b0)
        else $error("break sent a one");
    break_send_request_clr_a: assert property (brk_done |=> !break_send_request
        && shift_reg_empty) else $error("send request not cleared");
    shift_reg_empty_busy_a: assert property (brk_load_s |=> !shift_reg_empty [*8])
        else $error("shift empty during break");
    wue_clr_a: assert property (wue_clr |=> !wake_on_break_enable)
        else $error("wake enable not cleared");
    wake_flag_a: assert property (wake_ev |=> receive_flag_q)
        else $error("wake did not set flag");
    rd_clr_a: assert property (rd_hit && adr_i == SBW_RXD_OFS
        && !rx_done && !wake_ev |=> !receive_flag_q)
        else $error("read did not clear flag");
    sync_pins_a: assert property (sync_tx |-> data_line_oe_o
        && clock_line_oe_o) else $error("sync drivers off");
    // The clock register follows a polarity write one cycle later
    idle_pol_a: assert property (sync_mst && st_q == TX_IDLE
        && $stable(pol) |-> clock_line_o == pol)
        else $error("clock idle level wrong");
    sync_len_a: assert property (sync_load_s |=> bits_q == SBW_SYNC_BITS
        && sclk_q != pol) else $error("sync start wrong");
    transmit_buffer_empty_flag_a: assert property (load && !(wr_hit
        && adr_i == SBW_TXD_OFS) |=> transmit_buffer_empty_flag) else $error("buffer flag stuck");
    rx_susp_a: assert property (wake_on_break_enable |=> rx_idle && !rx_done)
        else $error("receiver ran during wake");
endmodule
`default_nettype wire

// >>> dv/sbw_node_model.sv
// Purpose: Far-side serial node: decodes async frames, captures sync bits
// Assumes: Its own sends use a 125 ns bit, data line has a pull-up
// Notes: The bench clears the sync counters before each sync send whose counts it checks
`default_nettype none
module sbw_node_model #(
    parameter int BIT_CYC = 12
) (
    // Clock
    input wire logic clk_i,
    // Lines from the block
    input wire logic ck_i,
    input wire logic ck_oe_i,
    input wire logic dt_i,
    input wire logic dt_oe_i,
    // Mode the node expects
    input wire logic sync_i,
    input wire logic pol_i,
    // Resolved data line level
    output logic dt_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv_en = 1'b0;
    logic drv_val = 1'b1;
    logic lead_val = 1'b0;
    logic [15:0] sbits = 16'h0;
    int sclocks = 0;
    int sync_err = 0;
    logic [11:0] frames[$];

    // Nobody driving: the pull-up wins
    assign dt_o = dt_oe_i ? dt_i : (drv_en ? drv_val : 1'b1);

    task automatic send_bits(input logic [15:0] bits, input int n);
        // Step off the clock edges so the line never moves on one
        #2;
        drv_en = 1'b1;
        for (int i = 0; i < n; i++) begin
            drv_val = bits[i];
            #125;
        end
        drv_val = 1'b1;
        drv_en = 1'b0;
    endtask

    // Mid-bit sampling; a low stop slot is followed to count the zeros
    initial begin
        logic [7:0] b;
        int z;
        forever begin
            @(posedge clk_i iff (!sync_i && ck_i === 1'b0));
            repeat (BIT_CYC / 2) @(posedge clk_i);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_CYC) @(posedge clk_i);
                if (i < 8) b[i] = ck_i;
            end
            z = 0;
            if (ck_i === 1'b0) begin
                z = 10;
                while (ck_i === 1'b0) begin
                    repeat (BIT_CYC) @(posedge clk_i);
                    if (ck_i === 1'b0) z++;
                end
            end
            frames.push_back({z[3:0], b});
            @(posedge clk_i iff ck_i === 1'b1);
        end
    end

    // Look 1 ns late so data launched with the clock edge has landed
    always @(ck_i) begin
        #1;
        if (sync_i) begin
            if (ck_i !== pol_i) begin
                lead_val = dt_i;
            end else begin
                if (dt_i !== lead_val || !dt_oe_i || !ck_oe_i) begin
                    sync_err++;
                end
                sbits = {dt_i, sbits[15:1]};
                sclocks++;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/sbw_top_bench.sv
// Purpose: Self-checking bench for the break, wake and sync-master block
// Assumes: Bit period of 12 clock cycles given through RATE_RST
// Notes: A watchdog on clock cycles ends a hung run
`default_nettype none
module sbw_top_bench import sbw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] RATE = 16'h000C;
    localparam int LIMIT = 20000;
    localparam logic [31:0] TRANSMIT_ENABLE = 32'h1 << SBW_C_TRANSMIT_ENABLE,
        BREAK_SEND_REQUEST = 32'h1 << SBW_C_BREAK_SEND_REQUEST, SYNC = 32'h1 << SBW_C_SYNC,
        CLOCK_SOURCE_MASTER = 32'h1 << SBW_C_CLOCK_SOURCE_MASTER, PEN = 32'h1 << SBW_C_PEN,
        CONTINUOUS_RECEIVE_ENABLE = 32'h1 << SBW_C_CONTINUOUS_RECEIVE_ENABLE, POL = 32'h1 << SBW_C_POL,
        WAKE_ON_BREAK_ENABLE = 32'h1 << SBW_C_WUE, SHIFT_REG_EMPTY = 32'h1 << SBW_S_SHIFT_REG_EMPTY,
        TRANSMIT_BUFFER_EMPTY_FLAG = 32'h1 << SBW_S_TRANSMIT_BUFFER_EMPTY_FLAG, RECEIVE_FLAG = 32'h1 << SBW_S_RECEIVE_FLAG,
        FRAMING_ERROR = 32'h1 << SBW_S_FRAMING_ERROR, RIDL = 32'h1 << SBW_S_RIDL;
    typedef struct packed {logic sy; logic pl; logic [7:0] d;} sbw_row_t;
    sbw_row_t rows [5] = '{'{1'b0, 1'b0, 8'hA5}, '{1'b0, 1'b0, 8'h00},
        '{1'b1, 1'b0, 8'h3C}, '{1'b1, 1'b1, 8'hC3}, '{1'b1, 1'b0, 8'h81}};
    logic clk_i, rst_i, cyc_i, stb_i, we_i, dl, md_sync, md_pol;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic ack_o, data_line_o, data_line_oe_o, clock_line_o, clock_line_oe_o;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    sbw_top #(.RATE_RST(RATE)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .data_line_i(dl), .data_line_o(data_line_o),
        .data_line_oe_o(data_line_oe_o), .clock_line_o(clock_line_o),
        .clock_line_oe_o(clock_line_oe_o));
    sbw_node_model #(.BIT_CYC(RATE)) i_node (.clk_i(clk_i),
        .ck_i(clock_line_o), .ck_oe_i(clock_line_oe_o), .dt_i(data_line_o),
        .dt_oe_i(data_line_oe_o), .sync_i(md_sync), .pol_i(md_pol),
        .dt_o(dl));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Request held until ack is sampled high at a rising edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i iff ack_o === 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q & m, exp);
    endtask

    // Load lands two edges after the write, so status is not read earlier
    task automatic wait_idle();
        logic [31:0] q;
        repeat (4) @(posedge clk_i);
        do begin
            wb(1'b0, SBW_STAT_OFS, 32'h0, q);
        end while ((q & (SHIFT_REG_EMPTY | TRANSMIT_BUFFER_EMPTY_FLAG)) !== (SHIFT_REG_EMPTY | TRANSMIT_BUFFER_EMPTY_FLAG));
    endtask

    initial begin
        {cyc_i, stb_i, we_i, md_sync, md_pol} = 5'h0;
        rst_i = 1'b1;
        adr_i = 8'h00;
        sel_i = 4'hF;
        dat_i = 32'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(SBW_CTRL_OFS, 32'hFFFFFFFF, 32'h0);
        rdc(SBW_STAT_OFS, SHIFT_REG_EMPTY | TRANSMIT_BUFFER_EMPTY_FLAG | RECEIVE_FLAG | FRAMING_ERROR, SHIFT_REG_EMPTY | TRANSMIT_BUFFER_EMPTY_FLAG);
        rdc(SBW_RATE_OFS, 32'hFFFFFFFF, {16'h0, RATE});
        rdc(8'h14, 32'hFFFFFFFF, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            md_pol = rows[i].pl;
            md_sync = rows[i].sy;
            wr(SBW_CTRL_OFS, rows[i].sy ? (TRANSMIT_ENABLE | SYNC | CLOCK_SOURCE_MASTER | PEN |
                (rows[i].pl ? POL : 32'h0)) : (TRANSMIT_ENABLE | PEN));
            repeat (4) @(posedge clk_i);
            i_node.sclocks = 0;
            i_node.sync_err = 0;
            wr(SBW_TXD_OFS, {24'h0, rows[i].d});
            wait_idle();
            if (rows[i].sy) begin
                chk(32'(i_node.sbits[15:8]), 32'(rows[i].d));
                chk(32'(i_node.sclocks), 32'h8);
                chk(32'(i_node.sync_err), 32'h0);
                chk(32'(clock_line_o), 32'(rows[i].pl));
            end else begin
                chk(32'(i_node.frames.pop_front()), {24'h0, rows[i].d});
            end
            $display("row %0d done", i);
        end
        wr(SBW_CTRL_OFS, TRANSMIT_ENABLE | SYNC | CLOCK_SOURCE_MASTER | PEN | CONTINUOUS_RECEIVE_ENABLE);
        i_node.sclocks = 0;
        wr(SBW_TXD_OFS, 32'h77);
        repeat (48) @(posedge clk_i);
        chk(32'(i_node.sclocks), 32'h0);
        chk(32'({clock_line_oe_o, data_line_oe_o}), 32'h2);
        md_pol = 1'b1;
        // The byte held during receive goes out once transmit is back
        wr(SBW_CTRL_OFS, TRANSMIT_ENABLE | SYNC | CLOCK_SOURCE_MASTER | PEN | POL);
        wait_idle();
        chk(32'(i_node.sbits[15:8]), 32'h77);
        i_node.sclocks = 0;
        i_node.sync_err = 0;
        wr(SBW_TXD_OFS, 32'h12);
        wr(SBW_TXD_OFS, 32'h34);
        rdc(SBW_STAT_OFS, TRANSMIT_BUFFER_EMPTY_FLAG, 32'h0);
        wait_idle();
        chk({16'h0, i_node.sbits}, 32'h3412);
        chk(32'(i_node.sclocks), 32'h10);
        chk(32'(i_node.sync_err), 32'h0);
        $display("sync back-to-back test done");
        wr(SBW_CTRL_OFS, TRANSMIT_ENABLE | PEN | BREAK_SEND_REQUEST);
        md_sync = 1'b0;
        wr(SBW_TXD_OFS, 32'hFF);
        wr(SBW_TXD_OFS, 32'h55);
        rdc(SBW_STAT_OFS, SHIFT_REG_EMPTY | TRANSMIT_BUFFER_EMPTY_FLAG, 32'h0);
        while (i_node.frames.size() < 2) @(posedge clk_i);
        wait_idle();
        chk(32'(i_node.frames.pop_front()), 32'hD00);
        chk(32'(i_node.frames.pop_front()), 32'h55);
        rdc(SBW_CTRL_OFS, 32'h1FF, TRANSMIT_ENABLE | PEN);
        $display("break send test done");
        wr(SBW_CTRL_OFS, PEN | CONTINUOUS_RECEIVE_ENABLE);
        i_node.send_bits(16'h2000, 14);
        repeat (20) @(posedge clk_i);
        rdc(SBW_STAT_OFS, RECEIVE_FLAG | FRAMING_ERROR, RECEIVE_FLAG | FRAMING_ERROR);
        rdc(SBW_RXD_OFS, 32'hFF, 32'h0);
        rdc(SBW_STAT_OFS, RECEIVE_FLAG, 32'h0);
        $display("break receive test done");
        rdc(SBW_STAT_OFS, RIDL, RIDL);
        wr(SBW_CTRL_OFS, PEN | CONTINUOUS_RECEIVE_ENABLE | WAKE_ON_BREAK_ENABLE);
        i_node.drv_en <= 1'b1;
        i_node.drv_val <= 1'b0;
        repeat (50) @(posedge clk_i);
        // Framing error stays from the break until the next character
        rdc(SBW_STAT_OFS, RECEIVE_FLAG | FRAMING_ERROR, RECEIVE_FLAG | FRAMING_ERROR);
        rdc(SBW_CTRL_OFS, WAKE_ON_BREAK_ENABLE, WAKE_ON_BREAK_ENABLE);
        i_node.drv_val <= 1'b1;
        repeat (10) @(posedge clk_i);
        rdc(SBW_CTRL_OFS, WAKE_ON_BREAK_ENABLE, 32'h0);
        rdc(SBW_RXD_OFS, 32'hFF, 32'h0);
        rdc(SBW_STAT_OFS, RECEIVE_FLAG, 32'h0);
        i_node.send_bits({6'h3F, 1'b1, 8'hA5, 1'b0}, 10);
        repeat (20) @(posedge clk_i);
        rdc(SBW_STAT_OFS, RECEIVE_FLAG | FRAMING_ERROR, RECEIVE_FLAG);
        rdc(SBW_RXD_OFS, 32'hFF, 32'hA5);
        $display("wake test done");
        md_sync = 1'b1;
        wr(SBW_CTRL_OFS, SYNC | CLOCK_SOURCE_MASTER | PEN | CONTINUOUS_RECEIVE_ENABLE | WAKE_ON_BREAK_ENABLE);
        i_node.drv_en <= 1'b1;
        i_node.drv_val <= 1'b0;
        repeat (20) @(posedge clk_i);
        i_node.drv_val <= 1'b1;
        repeat (10) @(posedge clk_i);
        rdc(SBW_STAT_OFS, RECEIVE_FLAG, 32'h0);
        rdc(SBW_CTRL_OFS, WAKE_ON_BREAK_ENABLE, WAKE_ON_BREAK_ENABLE);
        i_node.drv_en <= 1'b0;
        $display("sync wake test done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(SBW_CTRL_OFS, 32'hFFFFFFFF, 32'h0);
        rdc(SBW_STAT_OFS, SHIFT_REG_EMPTY | TRANSMIT_BUFFER_EMPTY_FLAG | RECEIVE_FLAG | FRAMING_ERROR, SHIFT_REG_EMPTY | TRANSMIT_BUFFER_EMPTY_FLAG);
        $display("reset again test done");
        complete_run();
    end
endmodule
`default_nettype wire
